// >>> dv/sba_alarm_props.sv
`default_nettype none
module sba_alarm_props (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic regRdEn,
  input wire logic regWrEn,
  input wire logic regRdValid,
  input wire logic clearBandsCmd,
  input wire logic saveBandsCmd,
  input wire logic bandSaveDone,
  input wire logic bandSaveIgnored,
  input wire logic recEnd,
  input wire logic recordDone,
  input wire logic digital_out_one,
  input wire logic digital_out_two
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  // a clear in the same cycle takes priority, so that save is not judged
  sequence saveReq;
    saveBandsCmd && !clearBandsCmd;
  endsequence
  chk_read_answer: assert property (regRdEn |=> regRdValid)
    else $error("read not answered");
  chk_read_quiet: assert property (!regRdEn |=> !regRdValid)
    else $error("read valid unasked");
  chk_save_answer: assert property (saveReq |=> bandSaveDone ^ bandSaveIgnored)
    else $error("save not answered once");
  chk_save_quiet: assert property (!saveBandsCmd |=> !bandSaveDone && !bandSaveIgnored)
    else $error("save answer unasked");
  chk_done_cause: assert property (recordDone |-> $past(recEnd))
    else $error("record done without end");
  chk_done_pulse: assert property (recordDone |=> !recordDone)
    else $error("record done too long");
  // pins decode registers only, so they move just after an update
  chk_pin_cause: assert property ($changed({digital_out_one, digital_out_two})
    && !$past(reset) |-> recordDone || $past(regWrEn)) else $error("alarm pin moved alone");
  chk_fault_warn: assert property (digital_out_two |-> digital_out_one)
    else $error("fault pin without warning");
endmodule // sba_alarm_props
bind sba_alarm_top sba_alarm_props chk (.sys_clk, .reset, .regRdEn, .regWrEn, .regRdValid,
  .clearBandsCmd, .saveBandsCmd, .bandSaveDone, .bandSaveIgnored, .recEnd, .recordDone,
  .digital_out_one, .digital_out_two);
`default_nettype wire

// >>> dv/sba_alarm_top_bench.sv
`default_nettype none
module sba_alarm_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk, reset, regWrEn, regRdEn, regRdValid, recStart, binValid, recEnd;
  logic        clearStatusCmd, clearBandsCmd, saveBandsCmd, bandSaveDone, bandSaveIgnored;
  logic        recordDone, sysValid, digital_out_one, digital_out_two;
  logic [1:0]  recRate;
  logic [6:0]  regAddr;
  logic [7:0]  binIndex;
  logic [15:0] regWrData, regRdData, binMagX, binMagY, sysTemp, sysSupply, diagEvents, junk;
  int          badCount, checksDone;
  logic [38:0] rows [12] = '{{7'h30, 16'hFFFF, 16'h0FFB}, {7'h2C, 16'hFFFF, 16'h0307},
    {7'h20, 16'hFFFF, 16'h0000}, {7'h2C, 16'h0305, 16'h0305}, {7'h20, 16'hABCD, 16'h00CD},
    {7'h22, 16'h1234, 16'h0034}, {7'h24, 16'h0100, 16'h0100}, {7'h28, 16'h0200, 16'h0200},
    {7'h26, 16'h0100, 16'h0100}, {7'h2A, 16'h0200, 16'h0200}, {7'h32, 16'hFFFF, 16'h0000},
    {7'h38, 16'hFFFF, 16'h0000}};
  sba_alarm_top dut (
    .sys_clk, .reset, .regAddr, .regWrEn, .regWrData, .regRdEn, .regRdData, .regRdValid,
    .clearStatusCmd, .clearBandsCmd, .saveBandsCmd, .bandSaveDone, .bandSaveIgnored,
    .recStart, .recRate, .binValid, .binIndex, .binMagX, .binMagY, .recEnd, .recordDone,
    .sysValid, .sysTemp, .sysSupply, .diagEvents, .digital_out_one, .digital_out_two);
  sba_host_model host (.sys_clk, .regAddr, .regWrEn, .regWrData, .regRdEn, .regRdData,
    .regRdValid);
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    checksDone++;
    if (g !== e) begin
      badCount++;
      $display("unexpected %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic rchk(input logic [6:0] a, input logic [15:0] e);
    host.xfer(1'b0, a, 16'h0000, junk);
    cmp(junk, e);
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] w);
    host.xfer(1'b1, a, w, junk);
  endtask
  task automatic save(input logic [15:0] e);
    @(posedge sys_clk) #2 saveBandsCmd = 1'b1;
    @(posedge sys_clk) #2 saveBandsCmd = 1'b0;
    cmp({14'h0000, bandSaveIgnored, bandSaveDone}, e);
  endtask
  task automatic rec(input logic [7:0] i, input logic [1:0] r, input logic [15:0] m, x);
    @(posedge sys_clk) #2 {recStart, recRate} = {1'b1, r};
    @(posedge sys_clk) #2 {recStart, binValid} = 2'b01;
    {binIndex, binMagX, binMagY} = {i, m, m};
    @(posedge sys_clk) #2 {binValid, recEnd} = 2'b01;
    @(posedge sys_clk) #2 recEnd = 1'b0;
    cmp({15'h0000, recordDone}, 16'h0001);
    rchk(7'h38, x);
    rchk(7'h3A, 16'h0000);
  endtask
  task automatic sys(input logic [15:0] c, input logic [15:0] e);
    wr(7'h30, c);
    @(posedge sys_clk) #2 sysValid = 1'b1;
    @(posedge sys_clk) #2 sysValid = 1'b0;
    rchk(7'h34, e);
  endtask
  task automatic summarize();
    if (badCount == 0 && checksDone > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #100000 badCount++;
    $display("unexpected %0t: run hung", $time);
    summarize();
  end
  initial begin
    reset = 1'b1;
    {clearStatusCmd, clearBandsCmd, saveBandsCmd, recStart, binValid, recEnd} = 6'h00;
    {sysValid, recRate, binIndex} = 11'h000;
    {binMagX, binMagY, sysTemp, sysSupply, diagEvents} = 80'h0;
    repeat (6) @(posedge sys_clk);
    #2 reset = 1'b0;
    rchk(7'h30, 16'h0080);
    foreach (rows[k]) begin
      wr(rows[k][38:32], rows[k][31:16]);
      rchk(rows[k][38:32], rows[k][15:0]);
    end
    wr(7'h2C, 16'h0101);
    rchk(7'h20, 16'h0000);
    @(posedge sys_clk) #2 diagEvents = 16'h0001;
    @(posedge sys_clk) #2 diagEvents = 16'h0000;
    rchk(7'h34, 16'h0001);
    @(posedge sys_clk) #2 clearStatusCmd = 1'b1;
    @(posedge sys_clk) #2 clearStatusCmd = 1'b0;
    rchk(7'h34, 16'h0000);
    @(posedge sys_clk) #2 clearBandsCmd = 1'b1;
    @(posedge sys_clk) #2 clearBandsCmd = 1'b0;
    wr(7'h2C, 16'h0001);
    wr(7'h20, 16'h000A);
    wr(7'h22, 16'h0014);
    save(16'h0001);
    wr(7'h20, 16'h000A);
    save(16'h0002);
    wr(7'h30, 16'h02C1);
    rec(8'h14, 2'h0, 16'h0300, 16'h0000);
    rec(8'h14, 2'h0, 16'h0300, 16'h0031);
    rchk(7'h3C, 16'h0300);
    rchk(7'h44, 16'h0014);
    cmp({14'h0000, digital_out_two, digital_out_one}, 16'h0003);
    rec(8'h15, 2'h0, 16'h0300, 16'h0000);
    rec(8'h0A, 2'h0, 16'h0150, 16'h0000);
    rec(8'h0A, 2'h0, 16'h0150, 16'h0011);
    cmp({14'h0000, digital_out_two, digital_out_one}, 16'h0001);
    rec(8'h14, 2'h1, 16'h0300, 16'h0000);
    wr(7'h2E, 16'h0100);
    {sysTemp, sysSupply} = {16'h0050, 16'h0500};
    sys(16'h0038, 16'h0100);
    sys(16'h0018, 16'h0000);
    sys(16'h0008, 16'h0100);
    sys(16'h0000, 16'h0000);
    summarize();
  end
endmodule // sba_alarm_top_bench
`default_nettype wire

// >>> dv/sba_host_model.sv
`default_nettype none
module sba_host_model (
  input  wire logic        sys_clk,
  output logic      [6:0]  regAddr,
  output logic             regWrEn,
  output logic      [15:0] regWrData,
  output logic             regRdEn,
  input  wire logic [15:0] regRdData,
  input  wire logic        regRdValid
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {regAddr, regWrEn, regWrData, regRdEn} = 25'h0;
  end
  // one access per call; released lines invert so stale values never look fresh
  task automatic xfer(input logic wr, input logic [6:0] a, input logic [15:0] w,
      output logic [15:0] d);
    @(posedge sys_clk) #2 {regAddr, regWrData, regWrEn, regRdEn} = {a, w, wr, !wr};
    @(posedge sys_clk) #2 {regAddr, regWrData, regWrEn, regRdEn} = {~a, ~w, 2'b00};
    d = regRdValid ? regRdData : 16'hxxxx;
  endtask
endmodule // sba_host_model
`default_nettype wire

// >>> verilog/sba_alarm_top.sv
// Summary of operation
// [R01] six bands, limits, warning/fault per axis
// [R02] limits stored per band and rate
// [R03] pointer bits 2:0 pick band
// [R04] pointer bits 9:8 pick rate option
// [R05] host sets pointer before limits
// [R06] lower limit bin in low byte
// [R07] upper limit bin in low byte
// [R08] config resets to 0x0080
// [R09] response delay counts records before flag
// [R10] bit 7 latches diagnostic flags
// [R11] bit 6 drives alarm output pins
// [R12] bit 5 selects below/above comparison
// [R13] bit 4 selects temperature or supply
// [R14] bit 3 enables system alarm
// [R15] bits 1:0 enable Y and X
// [R16] host keeps fault above warning
// [R17] status pairs per band, critical band
// [R18] clear before config, stale save ignored
// [R19] inclusive bin window against thresholds
// [R20] record rate limits, zero bands undefined
`include "sba_consts.svh"
`default_nettype none

module sba_alarm_top (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic [6:0]  regAddr,
  input  wire logic        regWrEn,
  input  wire logic [15:0] regWrData,
  input  wire logic        regRdEn,
  output logic      [15:0] regRdData,
  output logic             regRdValid,
  input  wire logic        clearStatusCmd,
  input  wire logic        clearBandsCmd,
  input  wire logic        saveBandsCmd,
  output logic             bandSaveDone,
  output logic             bandSaveIgnored,
  input  wire logic        recStart,
  input  wire logic [1:0]  recRate,
  input  wire logic        binValid,
  input  wire logic [7:0]  binIndex,
  input  wire logic [15:0] binMagX,
  input  wire logic [15:0] binMagY,
  input  wire logic        recEnd,
  output logic             recordDone,
  input  wire logic        sysValid,
  input  wire logic [15:0] sysTemp,
  input  wire logic [15:0] sysSupply,
  input  wire logic [15:0] diagEvents,
  output logic             digital_out_one,
  output logic             digital_out_two
);

  // ==========================================================
  // declarations
  sba_pkg::sba_bin_t lowBin_reg [`SBA_NUM_LIMITS];
  sba_pkg::sba_bin_t lowBin_next [`SBA_NUM_LIMITS];
  sba_pkg::sba_bin_t highBin_reg [`SBA_NUM_LIMITS];
  sba_pkg::sba_bin_t highBin_next [`SBA_NUM_LIMITS];
  logic [15:0] xWarn_reg, xWarn_next, yWarn_reg, yWarn_next;
  logic [15:0] xFault_reg, xFault_next, yFault_reg, yFault_next;
  logic [15:0] sysThr_reg, sysThr_next, config_reg, config_next;
  logic [1:0]  ptrRate_reg, ptrRate_next;
  logic [2:0]  ptrBand_reg, ptrBand_next;
  logic        cleared_reg, cleared_next, stale_reg, stale_next;
  logic        saveDone_reg, saveDone_next, saveIgn_reg, saveIgn_next;
  logic [15:0] rdData_reg, rdData_next;
  logic        rdValid_reg, rdValid_next;
  logic [15:0] diag_reg, diag_next;
  logic        sysAlarm_reg, sysAlarm_next;
  logic [1:0]  recRate_reg, recRate_next;
  sba_pkg::sba_state_t state_reg, state_next;
  logic        ptrValid, wrLow, wrHigh;
  logic [4:0]  ptrIdx;
  logic [47:0] recLows, recHighs;
  logic [15:0] xStatus, yStatus, xPeak, yPeak;
  logic [7:0]  xPeakBin, yPeakBin;
  logic        evStart, evBin, evEnd;
  logic [15:0] sysValue;

  // flat slot of a band/rate pair; band is 1..6
  function automatic logic [4:0] limitIdx(input logic [1:0] rate, input logic [2:0] band);
    limitIdx = 5'(rate) * 5'd6 + 5'(band) - 5'd1;
  endfunction

  // ==========================================================
  // pointer decode
  // [R03] band field selects slot
  // [R04] rate field selects slot
  assign ptrValid = (ptrBand_reg >= 3'd1) && (ptrBand_reg <= 3'd6);
  assign ptrIdx = limitIdx(ptrRate_reg, ptrBand_reg);
  // [R05] limits go where the pointer already sits
  assign wrLow = regWrEn && (regAddr == `SBA_ADDR_BAND_LOW) && ptrValid;
  assign wrHigh = regWrEn && (regAddr == `SBA_ADDR_BAND_HIGH) && ptrValid;

  // ==========================================================
  // configuration registers
  always_comb begin
    xWarn_next = xWarn_reg;
    yWarn_next = yWarn_reg;
    xFault_next = xFault_reg;
    yFault_next = yFault_reg;
    sysThr_next = sysThr_reg;
    config_next = config_reg;
    ptrRate_next = ptrRate_reg;
    ptrBand_next = ptrBand_reg;
    if (regWrEn) begin
      // [R01] per-axis warning and fault levels
      if (regAddr == `SBA_ADDR_X_WARN) begin
        xWarn_next = regWrData;
      end else if (regAddr == `SBA_ADDR_Y_WARN) begin
        yWarn_next = regWrData;
      end else if (regAddr == `SBA_ADDR_X_FAULT) begin
        xFault_next = regWrData;
      end else if (regAddr == `SBA_ADDR_Y_FAULT) begin
        yFault_next = regWrData;
      end else if (regAddr == `SBA_ADDR_POINTER) begin
        ptrRate_next = regWrData[`SBA_PTR_RATE_HI:`SBA_PTR_RATE_LO];
        ptrBand_next = regWrData[`SBA_PTR_BAND_HI:`SBA_PTR_BAND_LO];
      end else if (regAddr == `SBA_ADDR_SYS_THR) begin
        sysThr_next = regWrData;
      end else if (regAddr == `SBA_ADDR_CONFIG) begin
        // [R08] unused bits held at zero
        config_next = regWrData & `SBA_CFG_USED_MASK;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      xWarn_reg <= `SBA_ZERO16;
      yWarn_reg <= `SBA_ZERO16;
      xFault_reg <= `SBA_ZERO16;
      yFault_reg <= `SBA_ZERO16;
      sysThr_reg <= `SBA_ZERO16;
      // [R08] latching on, alarms off
      config_reg <= `SBA_CONFIG_RESET;
      ptrRate_reg <= 2'h0;
      ptrBand_reg <= 3'h0;
    end else begin
      xWarn_reg <= xWarn_next;
      yWarn_reg <= yWarn_next;
      xFault_reg <= xFault_next;
      yFault_reg <= yFault_next;
      sysThr_reg <= sysThr_next;
      config_reg <= config_next;
      ptrRate_reg <= ptrRate_next;
      ptrBand_reg <= ptrBand_next;
    end
  end

  // ==========================================================
  // band limit store with clear and save
  always_comb begin
    lowBin_next = lowBin_reg;
    highBin_next = highBin_reg;
    cleared_next = cleared_reg;
    stale_next = stale_reg;
    saveDone_next = 1'b0;
    saveIgn_next = 1'b0;
    // [R18] clear wipes every band definition
    if (clearBandsCmd) begin
      for (int i = 0; i < `SBA_NUM_LIMITS; i++) begin
        lowBin_next[i] = 8'h00;
        highBin_next[i] = 8'h00;
      end
      cleared_next = 1'b1;
      stale_next = 1'b0;
    end else if (saveBandsCmd) begin
      // [R18] save refused over uncleared writes
      saveIgn_next = stale_reg;
      saveDone_next = !stale_reg;
      cleared_next = stale_reg ? cleared_reg : 1'b0;
    end
    // a write in the clear cycle lands after the wipe
    if (wrLow || wrHigh) begin
      stale_next = stale_next || !cleared_next;
    end
    // [R02] [R06] low byte per band and rate
    if (wrLow) lowBin_next[ptrIdx] = regWrData[7:0];
    // [R07] upper limit in low byte
    if (wrHigh) highBin_next[ptrIdx] = regWrData[7:0];
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      for (int i = 0; i < `SBA_NUM_LIMITS; i++) begin
        lowBin_reg[i] <= 8'h00;
        highBin_reg[i] <= 8'h00;
      end
      cleared_reg <= 1'b1;
      stale_reg <= 1'b0;
      saveDone_reg <= 1'b0;
      saveIgn_reg <= 1'b0;
    end else begin
      lowBin_reg <= lowBin_next;
      highBin_reg <= highBin_next;
      cleared_reg <= cleared_next;
      stale_reg <= stale_next;
      saveDone_reg <= saveDone_next;
      saveIgn_reg <= saveIgn_next;
    end
  end

  // ==========================================================
  // record sequencing
  always_comb begin
    state_next = state_reg;
    recRate_next = recRate_reg;
    case (state_reg)
      sba_pkg::SBA_IDLE: begin
        if (recStart) begin
          state_next = sba_pkg::SBA_SCAN;
          recRate_next = recRate;
        end
      end
      sba_pkg::SBA_SCAN: begin
        if (recEnd) state_next = sba_pkg::SBA_DONE;
      end
      default: begin
        state_next = sba_pkg::SBA_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_reg <= sba_pkg::SBA_IDLE;
      recRate_reg <= 2'h0;
    end else begin
      state_reg <= state_next;
      recRate_reg <= recRate_next;
    end
  end

  assign evStart = recStart && (state_reg == sba_pkg::SBA_IDLE);
  assign evBin = binValid && (state_reg == sba_pkg::SBA_SCAN);
  assign evEnd = recEnd && !binValid && (state_reg == sba_pkg::SBA_SCAN);
  assign recordDone = (state_reg == sba_pkg::SBA_DONE);

  // [R20] limits of the record's own rate
  genvar g;
  generate
    for (g = 0; g < `SBA_NUM_BANDS; g++) begin : gLim
      assign recLows[g*8 +: 8] = lowBin_reg[limitIdx(recRate_reg, 3'(g + 1))];
      assign recHighs[g*8 +: 8] = highBin_reg[limitIdx(recRate_reg, 3'(g + 1))];
    end
  endgenerate

  // ==========================================================
  // per-axis evaluation
  // [R15] axis enables
  sba_axis_eval uXEval (
    .sys_clk    (sys_clk),
    .reset      (reset),
    .enable     (config_reg[`SBA_CFG_X_EN]),
    .recStart   (evStart),
    .binValid   (evBin),
    .binIndex   (binIndex),
    .binMag     (binMagX),
    .recEnd     (evEnd),
    .lowBins    (recLows),
    .highBins   (recHighs),
    .warnThr    (xWarn_reg),
    .faultThr   (xFault_reg),
    .respDelay  (config_reg[`SBA_CFG_DELAY_HI:`SBA_CFG_DELAY_LO]),
    .bandStatus (xStatus),
    .peakMag    (xPeak),
    .peakBin    (xPeakBin)
  );

  sba_axis_eval uYEval (
    .sys_clk    (sys_clk),
    .reset      (reset),
    .enable     (config_reg[`SBA_CFG_Y_EN]),
    .recStart   (evStart),
    .binValid   (evBin),
    .binIndex   (binIndex),
    .binMag     (binMagY),
    .recEnd     (evEnd),
    .lowBins    (recLows),
    .highBins   (recHighs),
    .warnThr    (yWarn_reg),
    .faultThr   (yFault_reg),
    .respDelay  (config_reg[`SBA_CFG_DELAY_HI:`SBA_CFG_DELAY_LO]),
    .bandStatus (yStatus),
    .peakMag    (yPeak),
    .peakBin    (yPeakBin)
  );

  // ==========================================================
  // system alarm and diagnostic flags
  // [R13] monitored quantity
  assign sysValue = config_reg[`SBA_CFG_SYS_TEMP] ? sysTemp : sysSupply;

  always_comb begin
    logic [15:0] ev;
    ev = diagEvents;
    sysAlarm_next = sysAlarm_reg;
    // [R14] disabled compare never alarms
    if (!config_reg[`SBA_CFG_SYS_EN]) begin
      sysAlarm_next = 1'b0;
    end else if (sysValid) begin
      // [R12] comparison polarity
      sysAlarm_next = config_reg[`SBA_CFG_SYS_BELOW] ? (sysValue < sysThr_reg)
                                                     : (sysValue > sysThr_reg);
    end
    ev[`SBA_DIAG_SYS_BIT] = ev[`SBA_DIAG_SYS_BIT] | sysAlarm_reg;
    // [R10] latch until clear, new events win
    if (config_reg[`SBA_CFG_LATCH]) begin
      diag_next = (clearStatusCmd ? `SBA_ZERO16 : diag_reg) | ev;
    end else begin
      diag_next = ev;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sysAlarm_reg <= 1'b0;
      diag_reg <= `SBA_ZERO16;
    end else begin
      sysAlarm_reg <= sysAlarm_next;
      diag_reg <= diag_next;
    end
  end

  // ==========================================================
  // register read port
  always_comb begin
    rdData_next = rdData_reg;
    rdValid_next = regRdEn;
    if (regRdEn) begin
      if (regAddr == `SBA_ADDR_BAND_LOW) begin
        rdData_next = ptrValid ? {8'h00, lowBin_reg[ptrIdx]} : `SBA_ZERO16;
      end else if (regAddr == `SBA_ADDR_BAND_HIGH) begin
        rdData_next = ptrValid ? {8'h00, highBin_reg[ptrIdx]} : `SBA_ZERO16;
      end else if (regAddr == `SBA_ADDR_X_WARN) begin
        rdData_next = xWarn_reg;
      end else if (regAddr == `SBA_ADDR_Y_WARN) begin
        rdData_next = yWarn_reg;
      end else if (regAddr == `SBA_ADDR_X_FAULT) begin
        rdData_next = xFault_reg;
      end else if (regAddr == `SBA_ADDR_Y_FAULT) begin
        rdData_next = yFault_reg;
      end else if (regAddr == `SBA_ADDR_POINTER) begin
        rdData_next = {6'h00, ptrRate_reg, 5'h00, ptrBand_reg};
      end else if (regAddr == `SBA_ADDR_SYS_THR) begin
        rdData_next = sysThr_reg;
      end else if (regAddr == `SBA_ADDR_CONFIG) begin
        rdData_next = config_reg;
      end else if (regAddr == `SBA_ADDR_DIAG) begin
        rdData_next = diag_reg;
      end else if (regAddr == `SBA_ADDR_X_FLAGS) begin
        rdData_next = xStatus;
      end else if (regAddr == `SBA_ADDR_Y_FLAGS) begin
        rdData_next = yStatus;
      end else if (regAddr == `SBA_ADDR_X_PEAK) begin
        rdData_next = xPeak;
      end else if (regAddr == `SBA_ADDR_Y_PEAK) begin
        rdData_next = yPeak;
      end else if (regAddr == `SBA_ADDR_X_FREQ) begin
        rdData_next = {8'h00, xPeakBin};
      end else if (regAddr == `SBA_ADDR_Y_FREQ) begin
        rdData_next = {8'h00, yPeakBin};
      end else begin
        rdData_next = `SBA_ZERO16;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rdData_reg <= `SBA_ZERO16;
      rdValid_reg <= 1'b0;
    end else begin
      rdData_reg <= rdData_next;
      rdValid_reg <= rdValid_next;
    end
  end

  assign regRdData = rdData_reg;
  assign regRdValid = rdValid_reg;
  assign bandSaveDone = saveDone_reg;
  assign bandSaveIgnored = saveIgn_reg;

  // ==========================================================
  // alarm indicator pins
  // [R11] warning on pin one, fault on pin two
  assign digital_out_one = config_reg[`SBA_CFG_DOUT_EN] && (|{xStatus[14], xStatus[12],
    xStatus[10], xStatus[8], xStatus[6], xStatus[4], yStatus[14], yStatus[12],
    yStatus[10], yStatus[8], yStatus[6], yStatus[4]});
  assign digital_out_two = config_reg[`SBA_CFG_DOUT_EN] && (|{xStatus[15], xStatus[13],
    xStatus[11], xStatus[9], xStatus[7], xStatus[5], yStatus[15], yStatus[13],
    yStatus[11], yStatus[9], yStatus[7], yStatus[5]});

endmodule : sba_alarm_top

`default_nettype wire

// >>> verilog/sba_axis_eval.sv
`include "sba_consts.svh"
`default_nettype none

module sba_axis_eval (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        enable,
  input  wire logic        recStart,
  input  wire logic        binValid,
  input  wire logic [7:0]  binIndex,
  input  wire logic [15:0] binMag,
  input  wire logic        recEnd,
  input  wire logic [47:0] lowBins,
  input  wire logic [47:0] highBins,
  input  wire logic [15:0] warnThr,
  input  wire logic [15:0] faultThr,
  input  wire logic [3:0]  respDelay,
  output logic      [15:0] bandStatus,
  output logic      [15:0] peakMag,
  output logic      [7:0]  peakBin
);

  // ==========================================================
  // bin window match
  logic [5:0]  inBand;
  logic [5:0]  warnHit_reg, warnHit_next, faultHit_reg, faultHit_next;
  logic [3:0]  warnCnt_reg [6];
  logic [3:0]  warnCnt_next [6];
  logic [3:0]  faultCnt_reg [6];
  logic [3:0]  faultCnt_next [6];
  logic [15:0] status_reg, status_next, peakMag_reg, peakMag_next;
  logic [7:0]  peakBin_reg, peakBin_next;

  genvar g;
  generate
    for (g = 0; g < `SBA_NUM_BANDS; g++) begin : gBand
      sba_pkg::sba_bin_t lo, hi;
      assign lo = lowBins[g*8 +: 8];
      assign hi = highBins[g*8 +: 8];
      // [R20] both-zero band is undefined
      // [R19] inclusive bin window
      assign inBand[g] = ((lo != 8'h00) || (hi != 8'h00)) && (binIndex >= lo)
                         && (binIndex <= hi);
    end
  endgenerate

  function automatic logic [3:0] satInc(input logic [3:0] c);
    satInc = (c == `SBA_CNT_MAX) ? c : 4'(c + 4'h1);
  endfunction

  // ==========================================================
  // record accumulation and flag update
  always_comb begin
    logic [2:0] critW, critF;
    logic [11:0] fl;
    critW = 3'h0;
    critF = 3'h0;
    fl = 12'h000;
    warnHit_next = warnHit_reg;
    faultHit_next = faultHit_reg;
    peakMag_next = peakMag_reg;
    peakBin_next = peakBin_reg;
    status_next = status_reg;
    warnCnt_next = warnCnt_reg;
    faultCnt_next = faultCnt_reg;
    if (recStart) begin
      warnHit_next = 6'h00;
      faultHit_next = 6'h00;
      peakMag_next = `SBA_ZERO16;
      peakBin_next = 8'h00;
    end else if (binValid) begin
      // [R19] both thresholds per bin
      if (binMag > warnThr) warnHit_next = warnHit_reg | inBand;
      if (binMag > faultThr) faultHit_next = faultHit_reg | inBand;
      if (binMag > peakMag_reg) begin
        peakMag_next = binMag;
        peakBin_next = binIndex;
      end
    end else if (recEnd) begin
      for (int b = 0; b < `SBA_NUM_BANDS; b++) begin
        // [R09] consecutive records before flag
        warnCnt_next[b] = (enable && warnHit_reg[b]) ? satInc(warnCnt_reg[b]) : 4'h0;
        faultCnt_next[b] = (enable && faultHit_reg[b]) ? satInc(faultCnt_reg[b]) : 4'h0;
        // [R15] disabled axis stays quiet
        fl[2*b] = enable && warnHit_reg[b] && (warnCnt_next[b] >= respDelay);
        fl[2*b+1] = enable && faultHit_reg[b] && (faultCnt_next[b] >= respDelay);
      end
      for (int b = `SBA_NUM_BANDS - 1; b >= 0; b--) begin
        if (fl[2*b]) critW = 3'(b + 1);
        if (fl[2*b+1]) critF = 3'(b + 1);
      end
      // [R17] pair layout and critical band
      status_next = {fl, 1'b0, (critF != 3'h0) ? critF : critW};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      warnHit_reg <= 6'h00;
      faultHit_reg <= 6'h00;
      peakMag_reg <= `SBA_ZERO16;
      peakBin_reg <= 8'h00;
      status_reg <= `SBA_ZERO16;
      for (int b = 0; b < `SBA_NUM_BANDS; b++) begin
        warnCnt_reg[b] <= 4'h0;
        faultCnt_reg[b] <= 4'h0;
      end
    end else begin
      warnHit_reg <= warnHit_next;
      faultHit_reg <= faultHit_next;
      peakMag_reg <= peakMag_next;
      peakBin_reg <= peakBin_next;
      status_reg <= status_next;
      warnCnt_reg <= warnCnt_next;
      faultCnt_reg <= faultCnt_next;
    end
  end

  assign bandStatus = status_reg;
  assign peakMag = peakMag_reg;
  assign peakBin = peakBin_reg;

endmodule : sba_axis_eval

`default_nettype wire

// >>> verilog/sba_consts.svh
`ifndef SBA_CONSTS_SVH
`define SBA_CONSTS_SVH

// ==========================================================
// register byte addresses
`define SBA_ADDR_BAND_LOW      7'h20
`define SBA_ADDR_BAND_HIGH     7'h22
`define SBA_ADDR_X_WARN        7'h24
`define SBA_ADDR_Y_WARN        7'h26
`define SBA_ADDR_X_FAULT       7'h28
`define SBA_ADDR_Y_FAULT       7'h2A
`define SBA_ADDR_POINTER       7'h2C
`define SBA_ADDR_SYS_THR       7'h2E
`define SBA_ADDR_CONFIG        7'h30
`define SBA_ADDR_DIAG          7'h34
`define SBA_ADDR_X_FLAGS       7'h38
`define SBA_ADDR_Y_FLAGS       7'h3A
`define SBA_ADDR_X_PEAK        7'h3C
`define SBA_ADDR_Y_PEAK        7'h3E
`define SBA_ADDR_X_FREQ        7'h44
`define SBA_ADDR_Y_FREQ        7'h46

// ==========================================================
// reset values
`define SBA_CONFIG_RESET       16'h0080
`define SBA_ZERO16             16'h0000

// ==========================================================
// field positions
`define SBA_CFG_DELAY_HI       11
`define SBA_CFG_DELAY_LO       8
`define SBA_CFG_LATCH          7
`define SBA_CFG_DOUT_EN        6
`define SBA_CFG_SYS_BELOW      5
`define SBA_CFG_SYS_TEMP       4
`define SBA_CFG_SYS_EN         3
`define SBA_CFG_Y_EN           1
`define SBA_CFG_X_EN           0
`define SBA_CFG_USED_MASK      16'h0FFB
`define SBA_PTR_RATE_HI        9
`define SBA_PTR_RATE_LO        8
`define SBA_PTR_BAND_HI        2
`define SBA_PTR_BAND_LO        0
`define SBA_DIAG_SYS_BIT       8

// ==========================================================
// sizes
`define SBA_NUM_BANDS          6
`define SBA_NUM_RATES          4
`define SBA_NUM_LIMITS         24
`define SBA_CNT_MAX            4'hF

`endif

// >>> verilog/sba_dummy_never.sv
`default_nettype none
`default_nettype wire

// >>> verilog/sba_pkg.sv
`default_nettype none

// ==========================================================
// shared types
package sba_pkg;
  // gray sequence along idle, scan, done
  typedef enum logic [1:0] {
    SBA_IDLE = 2'b00,
    SBA_SCAN = 2'b01,
    SBA_DONE = 2'b11
  } sba_state_t;

  typedef logic [7:0] sba_bin_t;
endpackage : sba_pkg

`default_nettype wire
